// >>> hw/srcmd_consts.vh
// constants for the serial remote command and value output block
`ifndef SRCMD_CONSTS_VH
`define SRCMD_CONSTS_VH
`define SRCMD_CH_ESC      8'h1B
`define SRCMD_CH_CR       8'h0D
`define SRCMD_CH_LF       8'h0A
`define SRCMD_CH_CTRLB    8'h02
`define SRCMD_CH_ZERO     8'h30
`define SRCMD_CH_NINE     8'h39
`define SRCMD_CH_T        8'h54
`define SRCMD_CH_A        8'h41
`define SRCMD_CH_S        8'h53
`define SRCMD_CH_EQ       8'h3D
`define SRCMD_CH_PLUS     8'h2B
`define SRCMD_CH_MINUS    8'h2D
`define SRCMD_CH_DOT      8'h2E
`define SRCMD_CH_BLANK    8'h20
`define SRCMD_CH_QUOTE    8'h22
`define SRCMD_CH_R        8'h52
`define SRCMD_CH_D        8'h44
`define SRCMD_CH_LOWCASE  8'h20
`define SRCMD_KEY_CLEAR   14'd100
`define SRCMD_KEY_MINUS   14'd101
`define SRCMD_KEY_POINT   14'd102
`define SRCMD_KEY_ENTER   14'd104
`define SRCMD_KEY_SOFT1   14'd114
`define SRCMD_KEY_SOFT6   14'd119
`define SRCMD_KEY_UP      14'd137
`define SRCMD_KEY_DOWN    14'd138
`define SRCMD_SCR_IDENT   14'd0
`define SRCMD_SCR_POS     14'd200
`define SRCMD_SPC_RESET   14'd0
`define SRCMD_SPC_LOCK    14'd1
`define SRCMD_SPC_UNLOCK  14'd2
`endif

// >>> hw/srcmd_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module srcmd_sync (
   input  wire sys_clk,
   input  wire reset_n,
   input  wire pinIn,
   output reg  levelOut
);
   reg [2:0] stageReg;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stageReg <= 3'h0;
         levelOut <= 1'b0;
      end else begin
         stageReg <= {stageReg[1:0], pinIn};
         // first stage is read only by the second
         if (stageReg[1] == stageReg[2])
            levelOut <= stageReg[2];
      end
   end
endmodule // srcmd_sync

// >>> hw/srcmd_top.v
// remote command decoder and measured-value line generator
// Summary of operation
// - serial side both receives and transmits characters
// - all payload is plain ASCII text
// - raw stream, no packets or acknowledgements
// - frame: ESC, class letter, four digits, CR
// - key commands act as local key presses
// - A0000 sends identity, A0200 sends position
// - Ctrl B or external input sends values
// - axis, equals, sign, digits, point, fraction
// - unit: blank for mm, quote inches
// - R/D actual, r/d distance-to-go
// - line ends with CR then LF
// - works with or without handshake lines
`timescale 1ns/1ps
`include "srcmd_consts.vh"
module srcmd_top #(
   parameter INT_MAX = 7,
   parameter FRC_MAX = 6
) (
   input  wire                      sys_clk,
   input  wire                      reset_n,
   input  wire [7:0]                rxData,
   input  wire                      rxValid,
   output wire [7:0]                txData,
   output wire                      txValid,
   input  wire                      txReady,
   input  wire                      ctsIn,
   input  wire                      handshakeEn,
   input  wire                      importMode,
   input  wire                      valueOutEn,
   input  wire                      external_trigger_input,
   input  wire [7:0]                axisLetter,
   input  wire                      valueNegative,
   input  wire [4*INT_MAX-1:0]      intDigits,
   input  wire [2:0]                intCount,
   input  wire [4*FRC_MAX-1:0]      frcDigits,
   input  wire [2:0]                frcCount,
   input  wire                      unitInch,
   input  wire                      diameterMode,
   input  wire                      distToGo,
   input  wire [7:0]                identChar,
   output reg  [7:0]                keyCode,
   output reg                       keyPulse,
   input  wire                      localKeyValid,
   input  wire [7:0]                localKeyCode,
   output reg                       keyLocked,
   output reg                       deviceReset,
   output reg  [7:0]                importData,
   output reg                       importValid
);
   // -------------------------------------------------------------
   // receive path: command frame parser
   // -------------------------------------------------------------
   localparam P_IDLE  = 4'b0001;
   localparam P_CLASS = 4'b0010;
   localparam P_DIG   = 4'b0100;
   localparam P_CR    = 4'b1000;

   reg [3:0]  pState_reg;
   reg [1:0]  cls_reg;
   reg [13:0] code_reg;
   reg [1:0]  digCnt_reg;
   reg        sendIdent_reg;
   reg        sendPos_reg;
   wire isDigit = (rxData >= `SRCMD_CH_ZERO) && (rxData <= `SRCMD_CH_NINE);
   wire [13:0] digVal = {10'h000, rxData[3:0]};
   wire [13:0] codeNext = code_reg * 14'd10 + digVal;
   wire        trigPin;

   srcmd_sync uSync (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .pinIn    (external_trigger_input),
      .levelOut (trigPin)
   );
   reg trigDly_reg;
   wire trigEdge = trigPin & ~trigDly_reg;
   wire ctrlB = rxValid && (rxData == `SRCMD_CH_CTRLB)
                && (pState_reg == P_IDLE) && !importMode;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pState_reg    <= P_IDLE;
         cls_reg       <= 2'h0;
         code_reg      <= 14'h0000;
         digCnt_reg    <= 2'h0;
         keyCode       <= 8'h00;
         keyPulse      <= 1'b0;
         keyLocked     <= 1'b0;
         deviceReset   <= 1'b0;
         sendIdent_reg <= 1'b0;
         sendPos_reg   <= 1'b0;
         importData    <= 8'h00;
         importValid   <= 1'b0;
         trigDly_reg   <= 1'b0;
      end else begin
         keyPulse      <= 1'b0;
         deviceReset   <= 1'b0;
         importValid   <= 1'b0;
         sendIdent_reg <= 1'b0;
         sendPos_reg   <= 1'b0;
         trigDly_reg   <= trigPin;
         // local keys pass unless locked
         if (localKeyValid && !keyLocked) begin
            keyCode  <= localKeyCode;
            keyPulse <= 1'b1;
         end
         if (rxValid && importMode) begin
            // raw file stream, no framing or checks
            importData  <= rxData;
            importValid <= 1'b1;
         end else if (rxValid) begin
            case (pState_reg)
               P_IDLE: begin
                  if (rxData == `SRCMD_CH_ESC)
                     pState_reg <= P_CLASS;
               end
               P_CLASS: begin
                  code_reg   <= 14'h0000;
                  digCnt_reg <= 2'h0;
                  pState_reg <= P_DIG;
                  if (rxData == `SRCMD_CH_T)
                     cls_reg <= 2'h1;
                  else if (rxData == `SRCMD_CH_A)
                     cls_reg <= 2'h2;
                  else if (rxData == `SRCMD_CH_S)
                     cls_reg <= 2'h3;
                  else
                     pState_reg <= P_IDLE;
               end
               P_DIG: begin
                  if (isDigit) begin
                     code_reg   <= codeNext;
                     digCnt_reg <= digCnt_reg + 2'h1;
                     if (digCnt_reg == 2'h3)
                        pState_reg <= P_CR;
                  end else begin
                     pState_reg <= P_IDLE;
                  end
               end
               P_CR: begin
                  pState_reg <= P_IDLE;
                  if (rxData == `SRCMD_CH_CR) begin
                     case (cls_reg)
                        2'h1: begin
                           // remote key bypasses local lock
                           if (code_reg <= 14'd9 ||
                               code_reg == `SRCMD_KEY_CLEAR ||
                               code_reg == `SRCMD_KEY_MINUS ||
                               code_reg == `SRCMD_KEY_POINT ||
                               code_reg == `SRCMD_KEY_ENTER ||
                               (code_reg >= `SRCMD_KEY_SOFT1 &&
                                code_reg <= `SRCMD_KEY_SOFT6) ||
                               code_reg == `SRCMD_KEY_UP ||
                               code_reg == `SRCMD_KEY_DOWN) begin
                              keyCode  <= code_reg[7:0];
                              keyPulse <= 1'b1;
                           end
                        end
                        2'h2: begin
                           if (code_reg == `SRCMD_SCR_IDENT)
                              sendIdent_reg <= 1'b1;
                           else if (code_reg == `SRCMD_SCR_POS)
                              sendPos_reg <= 1'b1;
                        end
                        default: begin
                           if (code_reg == `SRCMD_SPC_RESET) begin
                              deviceReset <= 1'b1;
                              keyLocked   <= 1'b0;
                           end else if (code_reg == `SRCMD_SPC_LOCK)
                              keyLocked <= 1'b1;
                           else if (code_reg == `SRCMD_SPC_UNLOCK)
                              keyLocked <= 1'b0;
                        end
                     endcase
                  end
               end
               default: pState_reg <= P_IDLE;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // transmit path: value line generator
   // -------------------------------------------------------------
   localparam T_IDLE = 8'b00000001;
   localparam T_AXIS = 8'b00000010;
   localparam T_EQ   = 8'b00000100;
   localparam T_SIGN = 8'b00001000;
   localparam T_INT  = 8'b00010000;
   localparam T_FRC  = 8'b00100000;
   localparam T_TAIL = 8'b01000000;
   localparam T_ID   = 8'b10000000;
   reg [7:0] tState_reg;
   reg [2:0] idx_reg;
   reg [1:0] tail_reg;
   reg [7:0] txData_reg;
   reg       pend_reg;
   reg       pendId_reg;
   reg       intDot_reg;
   // handshake line ignored when not wired
   wire adv = txReady && (ctsIn || !handshakeEn);
   assign txValid = (tState_reg != T_IDLE);
   assign txData  = txData_reg;
   wire [7:0] typeCh = (diameterMode ? `SRCMD_CH_D : `SRCMD_CH_R)
                       | (distToGo ? `SRCMD_CH_LOWCASE : 8'h00);
   wire       trig = (valueOutEn && (ctrlB || trigEdge)) || sendPos_reg;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tState_reg <= T_IDLE;
         idx_reg    <= 3'h0;
         tail_reg   <= 2'h0;
         txData_reg <= 8'h00;
         pend_reg   <= 1'b0;
         pendId_reg <= 1'b0;
         intDot_reg <= 1'b0;
      end else begin
         if (trig)
            pend_reg <= 1'b1;
         if (sendIdent_reg)
            pendId_reg <= 1'b1;
         case (tState_reg)
            T_IDLE: begin
               if (pendId_reg) begin
                  pendId_reg <= sendIdent_reg;
                  txData_reg <= identChar;
                  tail_reg   <= 2'h0;
                  tState_reg <= T_ID;
               end else if (pend_reg) begin
                  pend_reg   <= trig;
                  txData_reg <= axisLetter;
                  tState_reg <= T_AXIS;
               end
            end
            T_ID: if (adv) begin
               txData_reg <= `SRCMD_CH_CR;
               tail_reg   <= 2'h2;
               tState_reg <= T_TAIL;
            end
            T_AXIS: if (adv) begin
               txData_reg <= `SRCMD_CH_EQ;
               tState_reg <= T_EQ;
            end
            T_EQ: if (adv) begin
               txData_reg <= valueNegative ? `SRCMD_CH_MINUS
                                           : `SRCMD_CH_PLUS;
               tState_reg <= T_SIGN;
            end
            T_SIGN: if (adv) begin
               idx_reg    <= intCount - 3'h1;
               txData_reg <= {4'h3, intDigits[4*(intCount-3'h1) +: 4]};
               tState_reg <= T_INT;
            end
            T_INT: if (adv) begin
               if (intDot_reg) begin
                  intDot_reg <= 1'b0;
                  idx_reg    <= frcCount - 3'h1;
                  txData_reg <= {4'h3, frcDigits[4*(frcCount-3'h1) +: 4]};
                  tState_reg <= T_FRC;
               end else if (idx_reg == 3'h0) begin
                  intDot_reg <= 1'b1;
                  txData_reg <= `SRCMD_CH_DOT;
               end else begin
                  idx_reg    <= idx_reg - 3'h1;
                  txData_reg <= {4'h3, intDigits[4*(idx_reg-3'h1) +: 4]};
               end
            end
            T_FRC: if (adv) begin
               if (idx_reg == 3'h0) begin
                  txData_reg <= unitInch ? `SRCMD_CH_QUOTE
                                         : `SRCMD_CH_BLANK;
                  tail_reg   <= 2'h0;
                  tState_reg <= T_TAIL;
               end else begin
                  idx_reg    <= idx_reg - 3'h1;
                  txData_reg <= {4'h3, frcDigits[4*(idx_reg-3'h1) +: 4]};
               end
            end
            T_TAIL: if (adv) begin
               tail_reg <= tail_reg + 2'h1;
               case (tail_reg)
                  2'h0: txData_reg <= typeCh;
                  2'h1: txData_reg <= `SRCMD_CH_CR;
                  2'h2: txData_reg <= `SRCMD_CH_LF;
                  default: tState_reg <= T_IDLE;
               endcase
            end
            default: tState_reg <= T_IDLE;
         endcase
      end
   end
endmodule // srcmd_top

// >>> verif/srcmd_host_model.sv
// host terminal model that captures the block's character stream
`timescale 1ns/1ps
module srcmd_host_model (
   input  wire       sys_clk,
   input  wire       reset_n,
   input  wire [7:0] txData,
   input  wire       txValid,
   input  wire       handshakeEn,
   output reg        txReady,
   output reg        ctsIn,
   output reg  [7:0] gotChar,
   output reg        gotStrobe
);
   integer seed = 32'h8420;
   initial begin
      txReady = 1'b0;
      ctsIn = 1'b0;
      gotChar = 8'h00;
      gotStrobe = 1'b0;
   end
   // ------------------------------------------------------------
   // capture and stall
   // ------------------------------------------------------------
   // always capturing, so an export never starts before we listen
   always @(posedge sys_clk) begin
      gotStrobe <= reset_n && txValid && txReady
                   && (ctsIn || !handshakeEn);
      gotChar <= txData;
      #1;
      // clear-to-send also wanders when unwired; it must be ignored
      txReady = {$random(seed)} % 4 != 0;
      ctsIn = {$random(seed)} % 4 != 0;
   end
endmodule // srcmd_host_model

// >>> verif/srcmd_monitor.sv
// concurrent checks on the remote command block ports
`timescale 1ns/1ps
`include "srcmd_consts.vh"
module srcmd_monitor (
   input wire       sys_clk,
   input wire       reset_n,
   input wire [7:0] rxData,
   input wire       rxValid,
   input wire [7:0] txData,
   input wire       txValid,
   input wire       txReady,
   input wire       ctsIn,
   input wire       handshakeEn,
   input wire       importMode,
   input wire [7:0] axisLetter,
   input wire [7:0] identChar,
   input wire [7:0] keyCode,
   input wire       keyPulse,
   input wire       localKeyValid,
   input wire [7:0] localKeyCode,
   input wire       keyLocked,
   input wire       deviceReset,
   input wire [7:0] importData,
   input wire       importValid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire take = txValid && txReady && (ctsIn || !handshakeEn);
   // ------------------------------------------------------------
   // lock frame, key, reset, transmit and import checks
   // ------------------------------------------------------------
   sequence lockHead;
      rxValid && rxData == `SRCMD_CH_ESC && !importMode
      ##1 rxValid && rxData == `SRCMD_CH_S;
   endsequence
   sequence lockTail;
      (rxValid && rxData == 8'h30) [*3] ##1 rxValid && rxData == 8'h31
      ##1 rxValid && rxData == `SRCMD_CH_CR;
   endsequence
   chk_lock_frame: assert property (lockHead ##1 lockTail |=> keyLocked)
      else $error("lock frame did not lock keypad");
   chk_local_pass: assert property (localKeyValid && !keyLocked && !rxValid
      |=> keyPulse && keyCode == $past(localKeyCode))
      else $error("local key not passed");
   chk_lock_block: assert property (localKeyValid && keyLocked && !rxValid
      |=> !keyPulse)
      else $error("local key passed while locked");
   chk_reset_pulse: assert property (deviceReset |=> !deviceReset && !keyLocked)
      else $error("reset pulse too long or lock kept");
   chk_tx_hold: assert property (txValid && !take
      |=> txValid && $stable(txData))
      else $error("character changed before accept");
   chk_import_echo: assert property (importMode && rxValid
      |=> importValid && importData == $past(rxData))
      else $error("import byte not passed on");
   chk_line_end: assert property (take && txData == `SRCMD_CH_LF |=> !txValid)
      else $error("line did not end after line feed");
   chk_first_char: assert property ($rose(txValid)
      |-> txData == axisLetter || txData == identChar)
      else $error("line began with wrong character");
endmodule // srcmd_monitor
bind srcmd_top srcmd_monitor u_mon (.sys_clk, .reset_n, .rxData, .rxValid,
   .txData, .txValid, .txReady, .ctsIn, .handshakeEn, .importMode,
   .axisLetter, .identChar, .keyCode, .keyPulse, .localKeyValid,
   .localKeyCode, .keyLocked, .deviceReset, .importData, .importValid);

// >>> verif/tb_serial_remote_command_and_value_output.sv
// self-checking bench for the remote command block
`timescale 1ns/1ps
`include "srcmd_consts.vh"
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin numErrors++; \
   $display("mismatch %0s exp %0h got %0h", n, e, s); end end
module tb_serial_remote_command_and_value_output;
   reg         sys_clk = 0, reset_n = 0, rxValid = 0, extTrig = 0;
   reg         importMode = 0, valueOutEn = 1, handshakeEn = 0;
   reg         valueNegative = 0, unitInch = 0, diameterMode = 0;
   reg         distToGo = 0, localKeyValid = 0;
   reg  [7:0]  rxData = 0, axisLetter = 8'h58, identChar = 8'h49;
   reg  [7:0]  localKeyCode = 0, lastKey;
   reg  [27:0] intDigits = 0;
   reg  [23:0] frcDigits = 0;
   reg  [2:0]  intCount = 2, frcCount = 1;
   wire [7:0]  txData, keyCode, importData, gotChar;
   wire        txValid, txReady, ctsIn, keyPulse, keyLocked;
   wire        deviceReset, importValid, gotStrobe;
   integer     seed = 32'h8420, numErrors = 0, cmpCount = 0;
   integer     keyCnt = 0, rstCnt = 0, i, j, n;
   reg  [7:0]  expQ[$], gotQ[$], impQ[$];
   int keys[$] = {0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 100, 101, 102, 104,
                  114, 115, 116, 117, 118, 119, 137, 138};
   always #4 sys_clk = ~sys_clk;
   srcmd_top u_dut (.sys_clk, .reset_n, .rxData, .rxValid, .txData, .txValid,
      .txReady, .ctsIn, .handshakeEn, .importMode, .valueOutEn,
      .external_trigger_input(extTrig), .axisLetter, .valueNegative,
      .intDigits, .intCount, .frcDigits, .frcCount, .unitInch,
      .diameterMode, .distToGo, .identChar, .keyCode, .keyPulse,
      .localKeyValid, .localKeyCode, .keyLocked, .deviceReset,
      .importData, .importValid);
   srcmd_host_model u_host (.sys_clk, .reset_n, .txData, .txValid,
      .handshakeEn, .txReady, .ctsIn, .gotChar, .gotStrobe);
   always @(posedge sys_clk) begin
      if (keyPulse) begin keyCnt++; lastKey = keyCode; end
      if (deviceReset) rstCnt++;
      if (gotStrobe) gotQ.push_back(gotChar);
      if (importValid) impQ.push_back(importData);
   end
   // ------------------------------------------------------------
   // drivers and expectations
   // ------------------------------------------------------------
   task tick(input integer c); repeat (c) @(posedge sys_clk); #1; endtask
   function [7:0] dig(input integer v); dig = 8'h30 + v[7:0]; endfunction
   // seven characters, first in the top byte, sent back to back
   task sendSeq(input [55:0] s);
      for (j = 6; j >= 0; j--) begin rxData = s[8*j+:8]; rxValid = 1; tick(1); end
      rxValid = 0; tick(3);
   endtask
   task sendCmd(input [7:0] c, input integer v);
      sendSeq({`SRCMD_CH_ESC, c, dig(v / 1000), dig(v / 100 % 10),
               dig(v / 10 % 10), dig(v % 10), `SRCMD_CH_CR});
   endtask
   task sendB(input [7:0] b); rxData = b; rxValid = 1; tick(1); rxValid = 0; tick(1); endtask
   task localKey(input [7:0] c);
      localKeyCode = c; localKeyValid = 1; tick(1); localKeyValid = 0; tick(3);
   endtask
   task expLine;
      expQ = {axisLetter, `SRCMD_CH_EQ,
              valueNegative ? `SRCMD_CH_MINUS : `SRCMD_CH_PLUS};
      for (j = intCount - 1; j >= 0; j--) expQ.push_back(dig(intDigits[4*j+:4]));
      expQ.push_back(`SRCMD_CH_DOT);
      for (j = frcCount - 1; j >= 0; j--) expQ.push_back(dig(frcDigits[4*j+:4]));
      expQ.push_back(unitInch ? `SRCMD_CH_QUOTE : `SRCMD_CH_BLANK);
      expQ.push_back((diameterMode ? `SRCMD_CH_D : `SRCMD_CH_R)
                     | (distToGo ? `SRCMD_CH_LOWCASE : 8'h00));
      expQ.push_back(`SRCMD_CH_CR);
      expQ.push_back(`SRCMD_CH_LF);
   endtask
   task randVal;
      axisLetter = 8'h41 + {$random(seed)} % 26;
      {valueNegative, unitInch, diameterMode, distToGo} = $random(seed);
      intCount = 2 + {$random(seed)} % 6;
      frcCount = 1 + {$random(seed)} % 6;
      for (j = 0; j < 7; j++) intDigits[4*j+:4] = {$random(seed)} % 10;
      for (j = 0; j < 6; j++) frcDigits[4*j+:4] = {$random(seed)} % 10;
      handshakeEn = $random(seed);
   endtask
   task checkTx;
      for (i = 0; i < 600 && gotQ.size() < expQ.size(); i++) tick(1);
      tick(20);
      `CHK("lineLen", expQ.size(), gotQ.size())
      foreach (expQ[k]) `CHK("lineChar", expQ[k], gotQ[k])
      gotQ.delete();
   endtask
   task closeOut;
      if (numErrors == 0 && cmpCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin #400000; numErrors++; closeOut; end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      tick(5); reset_n = 1; tick(1);
      foreach (keys[k]) begin
         sendCmd(`SRCMD_CH_T, keys[k]);
         `CHK("keyCnt", k + 1, keyCnt)
         `CHK("keyCode", keys[k][7:0], lastKey)
      end
      n = keyCnt;
      sendCmd(`SRCMD_CH_S, 1); `CHK("locked", 1'b1, keyLocked)
      localKey(8'h35); `CHK("lockedKey", n, keyCnt)
      sendCmd(`SRCMD_CH_T, 104); `CHK("remoteKey", 8'h68, lastKey)
      sendCmd(`SRCMD_CH_S, 2); `CHK("unlocked", 1'b0, keyLocked)
      localKey(8'h35); `CHK("localKey", 8'h35, lastKey)
      sendCmd(`SRCMD_CH_S, 1); sendCmd(`SRCMD_CH_S, 0);
      `CHK("resetCnt", 1, rstCnt)
      `CHK("resetLock", 1'b0, keyLocked)
      n = keyCnt;
      sendSeq({8'h1B, 8'h54, "0x04", 8'h0D});
      sendSeq({8'h1B, 8'h51, "0104", 8'h0D});
      sendSeq({8'h1B, 8'h54, "0104", 8'h41});
      sendCmd(`SRCMD_CH_T, 200);
      `CHK("badFrames", n, keyCnt)
      sendCmd(`SRCMD_CH_T, 5); `CHK("recover", 8'h05, lastKey)
      for (n = 0; n < 9; n++) begin
         randVal;
         if (n == 0) begin intCount = 7; frcCount = 6; end
         if (n == 1) begin intCount = 2; frcCount = 1; end
         expLine;
         if (n % 3 == 2) sendCmd(`SRCMD_CH_A, 200);
         else if (n % 3 == 1) begin extTrig = 1; tick(8); extTrig = 0; end
         else sendB(`SRCMD_CH_CTRLB);
         checkTx;
      end
      identChar = 8'h41 + {$random(seed)} % 26;
      expQ = {identChar, `SRCMD_CH_CR, `SRCMD_CH_LF};
      sendCmd(`SRCMD_CH_A, 0); checkTx;
      valueOutEn = 0; expQ.delete();
      sendB(`SRCMD_CH_CTRLB); extTrig = 1; tick(8); extTrig = 0;
      checkTx;
      valueOutEn = 1;
      importMode = 1; tick(2);
      sendB(`SRCMD_CH_CTRLB); sendCmd(`SRCMD_CH_S, 1);
      checkTx;
      expQ = {8'h02, 8'h1B, 8'h53, 8'h30, 8'h30, 8'h30, 8'h31, 8'h0D};
      `CHK("impLen", 8, impQ.size())
      foreach (expQ[k]) `CHK("impData", expQ[k], impQ[k])
      `CHK("impNoCmd", 1'b0, keyLocked)
      importMode = 0; tick(2);
      closeOut;
   end
endmodule // tb_serial_remote_command_and_value_output
